/* nco_pkg.sv */
// Constants, register map and bus carrier of the oscillator block
package nco_pkg;
   localparam int ADDR_W = 3;
   localparam logic [2:0] CTRL_OFF = 3'h0;
   localparam logic [2:0] CLKC_OFF = 3'h1;
   localparam logic [2:0] ACCL_OFF = 3'h2;
   localparam logic [2:0] ACCH_OFF = 3'h3;
   localparam logic [2:0] ACCU_OFF = 3'h4;
   localparam logic [2:0] INCL_OFF = 3'h5;
   localparam logic [2:0] INCH_OFF = 3'h6;
   localparam logic [2:0] IRQ_OFF  = 3'h7;
   localparam int EN_BIT   = 7;
   localparam int OE_BIT   = 6;
   localparam int OUT_BIT  = 5;
   localparam int POL_BIT  = 4;
   localparam int PFM_BIT  = 0;
   localparam int PWS_LSB  = 5;
   localparam int CKS_LSB  = 0;
   localparam int FLAG_BIT = 0;
   localparam int IE_BIT   = 1;
   localparam logic [7:0] CTRL_WMASK = 8'hd1;
   localparam logic [7:0] CLKC_WMASK = 8'he3;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] CLKC_RST   = 8'h00;
   localparam logic [7:0] ACC_RST    = 8'h00;
   localparam logic [7:0] INCL_RST   = 8'h01;
   localparam logic [7:0] INCH_RST   = 8'h00;
   localparam logic [1:0] SRC_FAST   = 2'h0;
   localparam logic [1:0] SRC_SYS    = 2'h1;
   localparam logic [1:0] SRC_LC1    = 2'h2;
   localparam logic [1:0] SRC_EXT    = 2'h3;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              wr;
      logic              rd;
   } nco_bus_type;
endpackage

/* nco_top.sv */
// Numerically controlled oscillator with byte register port
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
module nco_top #(
   parameter int ACC_W = 20,
   parameter int INC_W = 16
) (
   // Clock and reset
   input  wire logic             I_CLK,
   input  wire logic             I_RST,
   // Register port
   input  wire nco_pkg::nco_bus_type I_BUS,
   output logic [7:0]            O_RDATA,
   // Selectable clock sources
   input  wire logic             I_FAST_OSC,
   input  wire logic             I_LOGIC_CELL_ONE,
   input  wire logic             I_EXT_CLK_PIN,
   // Interrupt enables kept outside
   input  wire logic             I_PERIPH_INT_EN,
   input  wire logic             I_GLOBAL_INT_EN,
   // Outputs
   output logic                  O_NCO_OUT,
   output logic                  O_PIN_OUT,
   output logic                  O_PIN_OE_N,
   output logic                  O_IRQ,
   output logic                  O_KEEP_FAST_OSC
);
   if (INC_W != 16 || ACC_W < 17 || ACC_W > 24) begin : g_chk
      $error("nco_top: INC_W must be 16 and ACC_W within 17..24");
   end

   function automatic logic hit(input nco_pkg::nco_bus_type b,
                                input logic [2:0] off);
      hit = b.wr && (b.addr == off);
   endfunction

   function automatic logic [7:0] width_m1(input logic [2:0] code);
      width_m1 = (8'h01 << code) - 8'h01;
   endfunction

   logic [7:0]       ctrl_reg;
   logic [7:0]       clkc_reg;
   logic [ACC_W-1:0] acc_reg;
   logic [7:0]       inc_low_reg;
   logic [7:0]       inc_high_reg;
   logic [INC_W-1:0] inc_work_reg;
   logic             load_pend_reg;
   logic             src_prev_reg;
   logic             toggle_reg;
   logic             pulse_pend_reg;
   logic             pulse_reg;
   logic [7:0]       pulse_cnt_reg;
   logic             flag_reg;
   logic             ie_reg;
   logic             out_reg;
   logic [7:0]       rdata_reg;
   logic             pin_reg;
   logic             oe_n_reg;
   logic             irq_reg;
   logic             keep_reg;

   logic             en;
   logic             pol;
   logic             pfm;
   logic [1:0]       cks;
   logic [2:0]       pws;
   logic             src_lvl;
   logic             tick;
   logic [ACC_W:0]   sum_w;
   logic             ovf;
   logic             raw;
   logic             final_lvl;
   logic             pol_evt;
   logic [7:0]       rd_val;

   assign en  = ctrl_reg[nco_pkg::EN_BIT];
   assign pol = ctrl_reg[nco_pkg::POL_BIT];
   assign pfm = ctrl_reg[nco_pkg::PFM_BIT];
   assign cks = clkc_reg[nco_pkg::CKS_LSB +: 2];
   assign pws = clkc_reg[nco_pkg::PWS_LSB +: 3];

   // Sources are sampled on I_CLK; a rising source edge becomes one tick
   always_comb begin
      unique case (cks)
         nco_pkg::SRC_FAST: src_lvl = I_FAST_OSC;
         nco_pkg::SRC_SYS:  src_lvl = 1'b1;
         nco_pkg::SRC_LC1:  src_lvl = I_LOGIC_CELL_ONE;
         nco_pkg::SRC_EXT:  src_lvl = I_EXT_CLK_PIN;
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         src_prev_reg <= 1'b0;
      end else begin
         src_prev_reg <= src_lvl;
      end
   end

   // System clock source ticks every cycle; the others on a rising level
   assign tick = en && ((cks == nco_pkg::SRC_SYS) || (src_lvl && !src_prev_reg));

   assign sum_w = {1'b0, acc_reg} + {{(ACC_W + 1 - INC_W){1'b0}}, inc_work_reg};
   assign ovf   = tick && sum_w[ACC_W];

   // Control registers; writes land in the single domain, so no crossing
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         ctrl_reg <= nco_pkg::CTRL_RST;
         clkc_reg <= nco_pkg::CLKC_RST;
      end else begin
         if (hit(I_BUS, nco_pkg::CTRL_OFF)) begin
            ctrl_reg <= I_BUS.wdata & nco_pkg::CTRL_WMASK;
         end
         if (hit(I_BUS, nco_pkg::CLKC_OFF)) begin
            clkc_reg <= I_BUS.wdata & nco_pkg::CLKC_WMASK;
         end
      end
   end

   // Software write of a byte beats the addition in the same cycle
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         acc_reg <= '0;
      end else if (hit(I_BUS, nco_pkg::ACCL_OFF)) begin
         acc_reg[7:0] <= I_BUS.wdata;
      end else if (hit(I_BUS, nco_pkg::ACCH_OFF)) begin
         acc_reg[15:8] <= I_BUS.wdata;
      end else if (hit(I_BUS, nco_pkg::ACCU_OFF)) begin
         acc_reg[ACC_W-1:16] <= I_BUS.wdata[ACC_W-17:0];
      end else if (tick) begin
         acc_reg <= sum_w[ACC_W-1:0];
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         inc_low_reg  <= nco_pkg::INCL_RST;
         inc_high_reg <= nco_pkg::INCH_RST;
      end else begin
         if (hit(I_BUS, nco_pkg::INCL_OFF)) begin
            inc_low_reg <= I_BUS.wdata;
         end
         if (hit(I_BUS, nco_pkg::INCH_OFF)) begin
            inc_high_reg <= I_BUS.wdata;
         end
      end
   end

   // While enabled, the working copy moves only on a tick after a low-byte write, so a half-written pair never adds; disabled, it follows directly
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         inc_work_reg  <= {nco_pkg::INCH_RST, nco_pkg::INCL_RST};
         load_pend_reg <= 1'b0;
      end else if (!en) begin
         inc_work_reg  <= {inc_high_reg, inc_low_reg};
         load_pend_reg <= 1'b0;
      end else begin
         if (load_pend_reg && tick) begin
            inc_work_reg <= {inc_high_reg, inc_low_reg};
         end
         if (hit(I_BUS, nco_pkg::INCL_OFF)) begin
            load_pend_reg <= 1'b1;
         end else if (tick) begin
            load_pend_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         toggle_reg <= 1'b0;
      end else if (!en) begin
         toggle_reg <= 1'b0;
      end else if (ovf) begin
         toggle_reg <= !toggle_reg;
      end
   end

   // Width beyond the overflow interval simply restarts the pulse
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         pulse_pend_reg <= 1'b0;
         pulse_reg      <= 1'b0;
         pulse_cnt_reg  <= 8'h00;
      end else if (!en) begin
         pulse_pend_reg <= 1'b0;
         pulse_reg      <= 1'b0;
         pulse_cnt_reg  <= 8'h00;
      end else if (tick) begin
         pulse_pend_reg <= sum_w[ACC_W];
         if (pulse_pend_reg) begin
            pulse_reg     <= 1'b1;
            pulse_cnt_reg <= width_m1(pws);
         end else if (pulse_reg) begin
            if (pulse_cnt_reg == 8'h00) begin
               pulse_reg <= 1'b0;
            end else begin
               pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
            end
         end
      end
   end

   assign raw       = pfm ? pulse_reg : toggle_reg;
   assign final_lvl = pol ? raw : !raw;

   // Any polarity flip inverts the final level, hence one transition
   assign pol_evt = hit(I_BUS, nco_pkg::CTRL_OFF) && ie_reg
                    && (I_BUS.wdata[nco_pkg::POL_BIT] != pol);

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         flag_reg <= 1'b0;
         ie_reg   <= 1'b0;
      end else begin
         if (ovf || pol_evt) begin
            flag_reg <= 1'b1;
         end else if (hit(I_BUS, nco_pkg::IRQ_OFF)) begin
            flag_reg <= I_BUS.wdata[nco_pkg::FLAG_BIT];
         end
         if (hit(I_BUS, nco_pkg::IRQ_OFF)) begin
            ie_reg <= I_BUS.wdata[nco_pkg::IE_BIT];
         end
      end
   end

   always_comb begin
      unique case (I_BUS.addr)
         nco_pkg::CTRL_OFF: rd_val = ctrl_reg | ({8{out_reg}} & (8'h01 << nco_pkg::OUT_BIT));
         nco_pkg::CLKC_OFF: rd_val = clkc_reg;
         nco_pkg::ACCL_OFF: rd_val = acc_reg[7:0];
         nco_pkg::ACCH_OFF: rd_val = acc_reg[15:8];
         nco_pkg::ACCU_OFF: rd_val = 8'(acc_reg[ACC_W-1:16]);
         nco_pkg::INCL_OFF: rd_val = inc_low_reg;
         nco_pkg::INCH_OFF: rd_val = inc_high_reg;
         nco_pkg::IRQ_OFF:  rd_val = {6'h00, ie_reg, flag_reg};
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= I_BUS.rd ? rd_val : 8'h00;
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         out_reg  <= 1'b0;
         pin_reg  <= 1'b0;
         oe_n_reg <= 1'b1;
      end else begin
         out_reg  <= final_lvl;
         pin_reg  <= final_lvl;
         oe_n_reg <= !ctrl_reg[nco_pkg::OE_BIT];
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         irq_reg  <= 1'b0;
         keep_reg <= 1'b0;
      end else begin
         irq_reg  <= flag_reg && ie_reg && en && I_PERIPH_INT_EN && I_GLOBAL_INT_EN;
         keep_reg <= en && (cks == nco_pkg::SRC_FAST);
      end
   end

   assign O_RDATA         = rdata_reg;
   assign O_NCO_OUT       = out_reg;
   assign O_PIN_OUT       = pin_reg;
   assign O_PIN_OE_N      = oe_n_reg;
   assign O_IRQ           = irq_reg;
   assign O_KEEP_FAST_OSC = keep_reg;

   // Checks
   logic [ACC_W-1:0] sum_lo;
   logic [INC_W-1:0] inc_cat;
   logic [7:0]       wm1;
   logic             acc_wr;
   assign sum_lo = sum_w[ACC_W-1:0];
   assign inc_cat = {inc_high_reg, inc_low_reg};
   assign wm1 = width_m1(pws);
   assign acc_wr = hit(I_BUS, nco_pkg::ACCL_OFF) || hit(I_BUS, nco_pkg::ACCH_OFF)
                   || hit(I_BUS, nco_pkg::ACCU_OFF);

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   property p_acc_step;
      tick && !acc_wr |=> acc_reg == $past(sum_lo);
   endproperty
   a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong");

   property p_inc_direct;
      !en ##1 !en |-> inc_work_reg == $past(inc_cat);
   endproperty
   a_inc_direct: assert property (p_inc_direct) else $error("increment not loaded");

   property p_fdc_toggle;
      ovf && !pfm |=> ##1 O_NCO_OUT != $past(O_NCO_OUT) || $changed(pol) || !en;
   endproperty
   a_fdc_toggle: assert property (p_fdc_toggle) else $error("no toggle on overflow");

   // Overflow arms the pulse; the following tick starts it with the full width
   sequence s_ovf_seen;
      en && pfm && ovf;
   endsequence
   sequence s_pend_tick;
      en && tick && pulse_pend_reg;
   endsequence
   sequence s_pulse_loaded;
      pulse_reg && pulse_cnt_reg == $past(wm1);
   endsequence
   property p_pf_pend;
      s_ovf_seen |=> pulse_pend_reg;
   endproperty
   a_pf_pend: assert property (p_pf_pend) else $error("pulse not armed");

   property p_pf_start;
      s_pend_tick |=> s_pulse_loaded;
   endproperty
   a_pf_start: assert property (p_pf_start) else $error("pulse start wrong");

   property p_pf_end;
      en && tick && pulse_reg && !pulse_pend_reg && pulse_cnt_reg == 8'h00 |=> !pulse_reg;
   endproperty
   a_pf_end: assert property (p_pf_end) else $error("pulse not ended");

   property p_status;
      I_BUS.rd && I_BUS.addr == nco_pkg::CTRL_OFF
         |=> O_RDATA[nco_pkg::OUT_BIT] == $past(out_reg);
   endproperty
   a_status: assert property (p_status) else $error("status bit wrong");

   property p_flag_hold;
      flag_reg && !hit(I_BUS, nco_pkg::IRQ_OFF) |=> flag_reg;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

   property p_irq;
      ovf && ie_reg && I_PERIPH_INT_EN && I_GLOBAL_INT_EN
         ##1 (en && ie_reg && I_PERIPH_INT_EN && I_GLOBAL_INT_EN) |=> O_IRQ;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_pin_oe;
      ctrl_reg[nco_pkg::OE_BIT] |=> !O_PIN_OE_N;
   endproperty
   a_pin_oe: assert property (p_pin_oe) else $error("pin not driven");

   property p_pin_release;
      !ctrl_reg[nco_pkg::OE_BIT] |=> O_PIN_OE_N;
   endproperty
   a_pin_release: assert property (p_pin_release) else $error("pin not released");

   property p_flag_set;
      ovf |=> flag_reg;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set on overflow");

   property p_pol_flag;
      hit(I_BUS, nco_pkg::CTRL_OFF) && ie_reg
         && I_BUS.wdata[nco_pkg::POL_BIT] != pol |=> flag_reg;
   endproperty
   a_pol_flag: assert property (p_pol_flag) else $error("polarity flag missing");

   property p_upper_zero;
      I_BUS.rd && I_BUS.addr == nco_pkg::ACCU_OFF |=> O_RDATA[7:4] == 4'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper nibble not zero");

   property p_keep;
      en && cks == nco_pkg::SRC_FAST |=> O_KEEP_FAST_OSC;
   endproperty
   a_keep: assert property (p_keep) else $error("fast source not kept");
endmodule

/* nco_far_side.sv */
// Far-side model: clock sources feeding the oscillator and the pin it drives
`timescale 1ns/1ns
module nco_far_side #(
   parameter int LC_HALF  = 2,
   parameter int EXT_HALF = 3
) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_pin_out,
   input  wire logic i_pin_oe_n,
   output logic      o_fast_osc,
   output logic      o_logic_cell,
   output logic      o_ext_clk,
   output logic      o_pin_level
);
   int cnt;

   // Free running, unrelated to the system clock, so sampling aliases on purpose
   initial begin
      o_fast_osc = 1'b0;
      forever #32 o_fast_osc = ~o_fast_osc;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt          <= 0;
         o_logic_cell <= 1'b0;
         o_ext_clk    <= 1'b0;
      end else begin
         cnt          <= cnt + 1;
         o_logic_cell <= (cnt % (2 * LC_HALF)) < LC_HALF;
         o_ext_clk    <= (cnt % (2 * EXT_HALF)) < EXT_HALF;
      end
   end

   // Weak pull-up holds the pin high once the module lets go of it
   assign o_pin_level = i_pin_oe_n ? 1'b1 : i_pin_out;
endmodule

/* tb_numerically_controlled_oscillator.sv */
// Self-checking bench for the numerically controlled oscillator
`timescale 1ns/1ns
module tb_numerically_controlled_oscillator;
   logic                 clk;
   logic                 rst;
   nco_pkg::nco_bus_type bus;
   logic [7:0]           rdata;
   logic                 fast, lcell, ext, pin, pe, ge;
   logic                 nco_out, pin_out, pin_oe_n, irq, keep;
   logic [7:0]           rv, v1, lo;
   int                   err_total;
   int                   comparisons;
   int                   regs [8];
   int                   span;
   int                   tp [4] = '{0, 1, 4, 6};

   nco_top dut (.I_CLK(clk), .I_RST(rst), .I_BUS(bus), .O_RDATA(rdata),
      .I_FAST_OSC(fast), .I_LOGIC_CELL_ONE(lcell), .I_EXT_CLK_PIN(ext),
      .I_PERIPH_INT_EN(pe), .I_GLOBAL_INT_EN(ge), .O_NCO_OUT(nco_out),
      .O_PIN_OUT(pin_out), .O_PIN_OE_N(pin_oe_n), .O_IRQ(irq), .O_KEEP_FAST_OSC(keep));

   nco_far_side far (.i_clk(clk), .i_rst(rst), .i_pin_out(pin_out), .i_pin_oe_n(pin_oe_n),
      .o_fast_osc(fast), .o_logic_cell(lcell), .o_ext_clk(ext), .o_pin_level(pin));

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("err_total %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge clk);
      bus.wr    <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge clk);
      bus.rd   <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   // Skips any partial phase, then counts how long the output stays at lvl
   task automatic gap(input logic lvl, output int n);
      int k;
      k = 0;
      n = 0;
      while (nco_out === lvl && k < 3000) begin
         @(negedge clk);
         k++;
      end
      while (nco_out !== lvl && k < 3000) begin
         @(negedge clk);
         k++;
      end
      while (nco_out === lvl && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (k >= 3000 || n >= 3000) begin
         err_total++;
         complete_run();
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      bus = '0;
      pe = 1'b1;
      ge = 1'b1;
      err_total = 0;
      comparisons = 0;
      void'($urandom(96));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      // Status bit shows the idle level: active low with raw output at rest
      for (int a = 0; a < 8; a++) begin
         regs[a] = (a == 0) ? 8'h20 : (a == 5) ? 8'h01 : 8'h00;
         rd(a[2:0], rv);
         check("reset value", 16'(regs[a]), {8'h00, rv});
      end
      for (int a = 1; a < 7; a++) begin
         regs[a] = $urandom % 256;
         wr(a[2:0], 8'(regs[a]));
      end
      for (int a = 1; a < 7; a++) begin
         rd(a[2:0], rv);
         lo = (a == 1) ? 8'he3 : (a == 4) ? 8'h0f : 8'hff;
         check("readback", 16'(regs[a] & lo), {8'h00, rv});
      end
      // Fixed duty, increment 0x8000: 32 ticks between overflows
      for (int a = 2; a < 5; a++) wr(a[2:0], 8'h00);
      wr(3'h6, 8'h80);
      wr(3'h5, 8'h00);
      wr(3'h7, 8'h02);
      wr(3'h0, 8'hd0);
      for (int s = 1; s < 4; s++) begin
         wr(3'h1, 8'(s));
         gap(1'b1, span);
         gap(1'b0, span);
         check("fixed half period", 16'(32 * tp[s]), 16'(span));
      end
      gap(1'b1, span);
      rd(3'h0, rv);
      check("status bit", 16'h00d0, {8'h00, rv});
      check("pin", {15'h0, nco_out}, {15'h0, pin});
      check("pin enable", 16'h0000, {15'h0, pin_oe_n});
      rd(3'h7, rv);
      check("flag", 16'h0003, {8'h00, rv});
      check("request", 16'h0001, {15'h0, irq});
      @(posedge clk);
      ge <= 1'b0;
      repeat (3) @(negedge clk);
      check("request masked", 16'h0000, {15'h0, irq});
      @(posedge clk);
      ge <= 1'b1;
      gap(1'b1, span);
      wr(3'h7, 8'h02);
      rd(3'h7, rv);
      check("flag cleared", 16'h0002, {8'h00, rv});
      gap(1'b1, span);
      rd(3'h7, rv);
      check("flag held", 16'h0003, {8'h00, rv});
      // Back on the system clock, so one tick per cycle from here on, apart from the short fast-source keep check
      wr(3'h1, 8'h01);
      // High byte alone must not reach the working increment
      wr(3'h6, 8'h40);
      gap(1'b1, span);
      gap(1'b0, span);
      check("buffered increment", 16'd32, 16'(span));
      wr(3'h5, 8'h00);
      gap(1'b1, span);
      gap(1'b0, span);
      check("loaded increment", 16'd64, 16'(span));
      lo = 8'($urandom % 256);
      wr(3'h6, 8'($urandom % 256));
      wr(3'h5, lo);
      @(posedge clk);
      bus.addr <= 3'h2;
      bus.rd   <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      v1 = rdata;
      @(posedge clk);
      bus.rd   <= 1'b0;
      @(negedge clk);
      check("accumulator step", {8'h00, lo}, {8'h00, rdata - v1});
      wr(3'h1, 8'h00);
      repeat (3) @(negedge clk);
      check("keep fast source", 16'h0001, {15'h0, keep});
      wr(3'h1, 8'h01);
      repeat (3) @(negedge clk);
      check("keep fast source", 16'h0000, {15'h0, keep});
      // Pulse mode with a 256-tick overflow interval covers all widths
      wr(3'h6, 8'h10);
      wr(3'h5, 8'h00);
      wr(3'h0, 8'hd1);
      for (int c = 0; c < 8; c++) begin
         wr(3'h1, {c[2:0], 5'h01});
         gap(1'b1, span);
         gap(1'b1, span);
         check("pulse width", 16'(1 << c), 16'(span));
      end
      wr(3'h0, 8'hc1);
      gap(1'b0, span);
      gap(1'b0, span);
      check("active low pulse", 16'd128, 16'(span));
      wr(3'h0, 8'h00);
      wr(3'h7, 8'h02);
      wr(3'h0, 8'h10);
      rd(3'h7, rv);
      check("polarity flag", 16'h0003, {8'h00, rv});
      check("disabled request", 16'h0000, {15'h0, irq});
      check("idle high polarity", 16'h0000, {15'h0, nco_out});
      check("pin released", 16'h0001, {15'h0, pin_oe_n});
      check("pin pulled up", 16'h0001, {15'h0, pin});
      complete_run();
   end
endmodule
